// ==== ata_tf_pkg.sv ====
package ata_tf_pkg;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  // host-side register offsets
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_ERROR = 4'h1;
  localparam logic [3:0] OFS_COUNT = 4'h2;
  localparam logic [3:0] OFS_SECTOR = 4'h3;
  localparam logic [3:0] OFS_CYL_LO = 4'h4;
  localparam logic [3:0] OFS_CYL_HI = 4'h5;
  localparam logic [3:0] OFS_UNIT_HEAD = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;
  localparam logic [3:0] OFS_DUP_EVEN = 4'h8;
  localparam logic [3:0] OFS_DUP_ODD = 4'h9;
  localparam logic [3:0] OFS_DUP_ERROR = 4'hD;
  localparam logic [3:0] OFS_ALT_STATUS = 4'hE;
  localparam logic [2:0] IDE_ALT_ADDR = 3'h6;
  // status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_WFAULT = 5;
  localparam int ST_SEEK = 4;
  localparam int ST_XFER = 3;
  localparam int ST_CORRECTED_FLAG = 2;
  localparam int ST_ERR = 0;
  // error cause bits that exist; 5, 3 and 1 always read zero
  localparam logic [7:0] ERR_DEFINED_MASK = 8'hD5;
  // unit/head fields
  localparam int DH_LINEAR_BIT = 6;
  localparam int DH_UNIT_BIT = 4;
  localparam logic [7:0] UNIT_HEAD_RESET = 8'hA0;
  // device control fields
  localparam int DC_SOFT_RESET_BIT = 2;
  localparam int DC_INT_DISABLE_BIT = 1;
  localparam logic [8:0] FULL_COUNT = 9'h100;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
endpackage

// ==== tf_access_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module tf_access_decode
  import ata_tf_pkg::*;
(
  // mode
  input wire logic true_ide,
  input wire logic io_mode,
  input wire logic eight_bit,
  // host selects
  input wire logic reg_n,
  input wire logic even_byte_enable_n,
  input wire logic odd_byte_enable_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic dmack_n,
  input wire logic [3:0] addr,
  // decoded access
  output logic hit,
  output logic is_data,
  output logic is_word,
  output logic fixed_odd,
  output logic paired,
  output logic hi_lane,
  output logic [3:0] offset
);
  always_comb begin
    hit = 1'b0;
    is_data = 1'b0;
    is_word = 1'b0;
    fixed_odd = 1'b0;
    paired = 1'b0;
    hi_lane = 1'b0;
    offset = addr;
    if (true_ide) begin
      if (!dmack_n && cs0_n && cs1_n) begin
        // address lines do not matter for dma words
        hit = 1'b1;
        is_data = 1'b1;
        is_word = 1'b1;
      end else if (dmack_n && cs1_n && !cs0_n) begin
        hit = 1'b1;
        offset = {1'b0, addr[2:0]};
        if (addr[2:0] == OFS_DATA[2:0]) begin
          is_data = 1'b1;
          is_word = !eight_bit;
          paired = eight_bit;
        end
      end else if (dmack_n && !cs1_n && cs0_n && addr[2:0] == IDE_ALT_ADDR) begin
        hit = 1'b1;
        offset = OFS_ALT_STATUS;
      end
    end else if (reg_n != io_mode && !(even_byte_enable_n && odd_byte_enable_n)) begin
      // attribute select low for i/o, high for memory mode
      hit = 1'b1;
      if (!even_byte_enable_n && !odd_byte_enable_n) begin
        if (addr == OFS_DATA || addr == OFS_DUP_EVEN || addr == OFS_DUP_ODD) begin
          is_data = 1'b1;
          is_word = 1'b1;
        end
      end else if (!even_byte_enable_n) begin
        case (addr)
          OFS_DATA: begin
            is_data = 1'b1;
            paired = 1'b1;
          end
          OFS_DUP_EVEN: is_data = 1'b1;
          OFS_DUP_ODD: begin
            is_data = 1'b1;
            fixed_odd = 1'b1;
          end
          OFS_DUP_ERROR: offset = OFS_ERROR;
          default: offset = addr;
        endcase
      end else begin
        hi_lane = 1'b1;
        if (addr == OFS_DATA) begin
          offset = OFS_ERROR;
        end else if (addr == OFS_DUP_EVEN || addr == OFS_DUP_ODD) begin
          is_data = 1'b1;
          fixed_odd = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== word_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_st_t;
  fifo_st_t st_reg, st_next;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;
  assign in_ready = !(st_reg.wp[AW] != st_reg.rp[AW] && st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
  assign out_valid = st_reg.wp != st_reg.rp;
  assign out_data = mem[st_reg.rp[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    st_next = st_reg;
    if (push) st_next.wp = st_reg.wp + 1'b1;
    if (pop) st_next.rp = st_reg.rp + 1'b1;
  end
  always_ff @(posedge clk) begin
    if (rst) st_reg <= '0;
    else st_reg <= st_next;
  end
  // storage has no reset, only pointers do
  always_ff @(posedge clk) begin
    if (push) mem[st_reg.wp[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// ==== ata_task_file_registers.sv ====
// Functional notes
// - sixteen-bit data port shares offset with error
// - hi-lane read at offset 0 gives error
// - hi-lane write at offset 0 loads feature
// - error bit 7 bad block or crc
// - bits 6,4,0 set; 5,3,1 read zero
// - error bit 2 on aborted command
// - zero sector count means 256 sectors
// - count zero on success, remainder on failure
// - linear address built from four registers
// - unit/head bit 6 selects addressing mode
// - unit bit matched against copy field
// - low four bits give head number
// - status read clears interrupt, alternate not
// - busy locks host out of command, buffer
// - dma request only with busy or request
// - ready clear until core ready; seek follows
// - status bit 5 shows write fault
// - status bit 3 requests data word
// - correction flag, no abort; bit 1 zero
// - error bit; failing address kept
// - interrupt forwarded only when not disabled
// - hi-lane byte at offset 0 hits error/feature
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_registers
  import ata_tf_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // mode straps
  input wire logic TRUE_IDE,
  input wire logic IO_MODE,
  // host selects and strobes
  input wire logic REG_N,
  input wire logic EVEN_BYTE_ENABLE_N,
  input wire logic ODD_BYTE_ENABLE_N,
  input wire logic CS0_N,
  input wire logic CS1_N,
  input wire logic DMACK_N,
  input wire logic [3:0] ADDR,
  input wire logic RD_N,
  input wire logic WR_N,
  // host data bus
  input wire logic [15:0] D_IN,
  output logic [15:0] D_OUT,
  output logic D_OE,
  // host requests
  output logic INTRQ,
  output logic DMARQ,
  // core status
  input wire logic CORE_READY,
  input wire logic CORE_BUSY,
  input wire logic CORE_UNIT_COPY,
  input wire logic CORE_EIGHT_BIT,
  input wire logic CORE_XFER_REQ,
  input wire logic CORE_WRITE_DIR,
  input wire logic CORE_DMA_REQ,
  // core events
  input wire logic CORE_SECTOR_DONE,
  input wire logic CORE_CORRECTED,
  input wire logic CORE_DONE,
  input wire logic [7:0] CORE_ERR_BITS,
  input wire logic CORE_WRITE_FAULT,
  input wire logic [27:0] CORE_FAIL_ADDR,
  // command to core
  output logic CMD_VALID,
  output logic [7:0] CMD_CODE,
  output logic [7:0] FEATURE,
  output logic [8:0] SECTOR_TOTAL,
  output logic LINEAR_BLOCK_MODE,
  output logic [27:0] BLOCK_ADDR,
  output logic [15:0] CYLINDER,
  output logic [3:0] HEAD,
  output logic SOFT_RESET,
  // read words from the sector buffer
  input wire logic [15:0] CORE_RDATA,
  input wire logic CORE_RVALID,
  output logic CORE_RREADY,
  // write words to the sector buffer
  output logic [15:0] CORE_WDATA,
  output logic CORE_WVALID,
  input wire logic CORE_WREADY
);
  typedef struct packed {
    logic rd_prev;
    logic wr_prev;
    logic rd_oe;
    logic [15:0] rd_data;
    logic [7:0] error_cause;
    logic [7:0] feature_select;
    logic [7:0] sector_count;
    logic [7:0] start_sector_low;
    logic [7:0] cylinder_low_byte;
    logic [7:0] cylinder_high_byte;
    logic [7:0] unit_head_select;
    logic busy;
    logic corrected_flag;
    logic write_fault_flag;
    logic err;
    logic int_pend;
    logic interrupt_disable;
    logic soft_reset;
    logic [7:0] cmd_code;
    logic cmd_pulse;
    logic pair_odd;
    logic [7:0] wr_low;
    logic pop;
    logic push;
    logic [15:0] push_data;
  } tf_state_t;

  tf_state_t st_reg, st_next;
  logic hit, is_data, is_word, fixed_odd, paired, hi_lane;
  logic [3:0] offset;
  logic fifo_ready;
  logic busy_any;
  logic selected;
  logic transfer_request;
  logic [7:0] status_val;

  tf_access_decode u_decode (
    .true_ide(TRUE_IDE),
    .io_mode(IO_MODE),
    .eight_bit(CORE_EIGHT_BIT),
    .reg_n(REG_N),
    .even_byte_enable_n(EVEN_BYTE_ENABLE_N),
    .odd_byte_enable_n(ODD_BYTE_ENABLE_N),
    .cs0_n(CS0_N),
    .cs1_n(CS1_N),
    .dmack_n(DMACK_N),
    .addr(ADDR),
    .hit(hit),
    .is_data(is_data),
    .is_word(is_word),
    .fixed_odd(fixed_odd),
    .paired(paired),
    .hi_lane(hi_lane),
    .offset(offset)
  );

  // host words wait here; a full buffer drops the request flag so the host pauses
  word_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst(SYS_RST),
    .in_valid(st_reg.push),
    .in_ready(fifo_ready),
    .in_data(st_reg.push_data),
    .out_valid(CORE_WVALID),
    .out_ready(CORE_WREADY),
    .out_data(CORE_WDATA)
  );

  assign busy_any = st_reg.busy || CORE_BUSY;
  assign selected = st_reg.unit_head_select[DH_UNIT_BIT] == CORE_UNIT_COPY;
  assign transfer_request = CORE_XFER_REQ && (CORE_WRITE_DIR ? fifo_ready : CORE_RVALID);

  always_comb begin
    status_val = ZERO8;
    if (busy_any) begin
      // other bits are meaningless while busy, so they read zero
      status_val[ST_BUSY] = 1'b1;
    end else begin
      status_val[ST_READY] = CORE_READY;
      status_val[ST_SEEK] = CORE_READY;
      status_val[ST_WFAULT] = st_reg.write_fault_flag;
      status_val[ST_XFER] = transfer_request;
      status_val[ST_CORRECTED_FLAG] = st_reg.corrected_flag;
      status_val[ST_ERR] = st_reg.err;
    end
  end

  always_comb begin
    logic rd_go;
    logic wr_go;
    logic odd;
    logic [7:0] wbyte;
    logic [7:0] rval;
    rd_go = 1'b0;
    wr_go = 1'b0;
    odd = 1'b0;
    wbyte = ZERO8;
    rval = ZERO8;
    st_next = st_reg;
    st_next.cmd_pulse = 1'b0;
    st_next.pop = 1'b0;
    st_next.push = 1'b0;
    st_next.rd_prev = RD_N;
    st_next.wr_prev = WR_N;
    rd_go = hit && !RD_N && st_reg.rd_prev;
    wr_go = hit && !WR_N && st_reg.wr_prev;
    odd = paired ? st_reg.pair_odd : fixed_odd;
    wbyte = hi_lane ? D_IN[15:8] : D_IN[7:0];
    if (RD_N) st_next.rd_oe = 1'b0;

    if (rd_go) begin
      st_next.rd_oe = selected;
      if (is_data) begin
        // even byte first, odd byte completes the word and releases it
        if (is_word) begin
          st_next.rd_data = CORE_RDATA;
        end else begin
          rval = odd ? CORE_RDATA[15:8] : CORE_RDATA[7:0];
          st_next.rd_data = hi_lane ? {rval, ZERO8} : {ZERO8, rval};
        end
        st_next.pop = !busy_any && (is_word || odd) && CORE_RVALID;
        if (paired) st_next.pair_odd = !st_reg.pair_odd;
      end else begin
        case (offset)
          OFS_ERROR: rval = st_reg.error_cause & ERR_DEFINED_MASK;
          OFS_COUNT: rval = st_reg.sector_count;
          OFS_SECTOR: rval = st_reg.start_sector_low;
          OFS_CYL_LO: rval = st_reg.cylinder_low_byte;
          OFS_CYL_HI: rval = st_reg.cylinder_high_byte;
          OFS_UNIT_HEAD: rval = st_reg.unit_head_select;
          OFS_STATUS: rval = status_val;
          OFS_ALT_STATUS: rval = status_val;
          default: rval = ZERO8;
        endcase
        st_next.rd_data = hi_lane ? {rval, ZERO8} : {ZERO8, rval};
        if (offset == OFS_STATUS && selected) st_next.int_pend = 1'b0;
      end
    end

    if (wr_go && offset == OFS_ALT_STATUS && !is_data) begin
      // device control is writable even while busy
      st_next.interrupt_disable = wbyte[DC_INT_DISABLE_BIT];
      st_next.soft_reset = wbyte[DC_SOFT_RESET_BIT];
    end else if (wr_go && !busy_any) begin
      if (is_data) begin
        if (is_word) begin
          st_next.push = 1'b1;
          st_next.push_data = D_IN;
        end else if (odd) begin
          st_next.push = 1'b1;
          st_next.push_data = {wbyte, st_reg.wr_low};
        end else begin
          st_next.wr_low = wbyte;
        end
        if (paired) st_next.pair_odd = !st_reg.pair_odd;
      end else begin
        case (offset)
          OFS_ERROR: st_next.feature_select = wbyte;
          OFS_COUNT: st_next.sector_count = wbyte;
          OFS_SECTOR: st_next.start_sector_low = wbyte;
          OFS_CYL_LO: st_next.cylinder_low_byte = wbyte;
          OFS_CYL_HI: st_next.cylinder_high_byte = wbyte;
          OFS_UNIT_HEAD: st_next.unit_head_select = wbyte;
          OFS_STATUS: begin
            if (selected && !st_reg.soft_reset) begin
              st_next.cmd_code = wbyte;
              st_next.cmd_pulse = 1'b1;
              st_next.busy = 1'b1;
              st_next.error_cause = ZERO8;
              st_next.err = 1'b0;
              st_next.corrected_flag = 1'b0;
              st_next.write_fault_flag = 1'b0;
              st_next.int_pend = 1'b0;
              st_next.pair_odd = 1'b0;
            end
          end
          default: st_next.pair_odd = st_next.pair_odd;
        endcase
      end
    end

    // core events come last so a set in the same cycle beats a host clear
    if (CORE_SECTOR_DONE) begin
      st_next.sector_count = st_reg.sector_count - ONE8;
    end
    if (CORE_CORRECTED) begin
      st_next.corrected_flag = 1'b1; // busy untouched, reads keep going
    end
    if (CORE_DONE) begin
      st_next.busy = 1'b0;
      st_next.int_pend = 1'b1;
      st_next.write_fault_flag = CORE_WRITE_FAULT;
      st_next.error_cause = CORE_ERR_BITS & ERR_DEFINED_MASK;
      st_next.err = |(CORE_ERR_BITS & ERR_DEFINED_MASK);
      if (|(CORE_ERR_BITS & ERR_DEFINED_MASK)) begin
        // first failing sector stays visible to the host
        st_next.start_sector_low = CORE_FAIL_ADDR[7:0];
        st_next.cylinder_low_byte = CORE_FAIL_ADDR[15:8];
        st_next.cylinder_high_byte = CORE_FAIL_ADDR[23:16];
        st_next.unit_head_select[3:0] = CORE_FAIL_ADDR[27:24];
      end else begin
        st_next.sector_count = ZERO8;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
      st_reg.rd_prev <= 1'b1;
      st_reg.wr_prev <= 1'b1;
      st_reg.unit_head_select <= UNIT_HEAD_RESET;
      st_reg.interrupt_disable <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // host-facing outputs
  assign D_OUT = st_reg.rd_data;
  assign D_OE = st_reg.rd_oe && !RD_N;
  assign INTRQ = st_reg.int_pend && !st_reg.interrupt_disable;
  assign DMARQ = CORE_DMA_REQ && (busy_any || transfer_request);

  // core-facing outputs
  assign CMD_VALID = st_reg.cmd_pulse;
  assign CMD_CODE = st_reg.cmd_code;
  assign FEATURE = st_reg.feature_select;
  assign SECTOR_TOTAL = (st_reg.sector_count == ZERO8) ? FULL_COUNT : {1'b0, st_reg.sector_count};
  assign LINEAR_BLOCK_MODE = st_reg.unit_head_select[DH_LINEAR_BIT];
  assign BLOCK_ADDR = {st_reg.unit_head_select[3:0], st_reg.cylinder_high_byte,
                       st_reg.cylinder_low_byte, st_reg.start_sector_low};
  assign CYLINDER = {st_reg.cylinder_high_byte, st_reg.cylinder_low_byte};
  assign HEAD = st_reg.unit_head_select[3:0];
  assign SOFT_RESET = st_reg.soft_reset;
  assign CORE_RREADY = st_reg.pop;
  // bits 7 and 5 of unit/head are stored as written and never steer anything
endmodule
`default_nettype wire

// ==== ata_task_file_registers_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_registers_asserts
  import ata_tf_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // host side
  input wire logic TRUE_IDE,
  input wire logic IO_MODE,
  input wire logic REG_N,
  input wire logic EVEN_BYTE_ENABLE_N,
  input wire logic ODD_BYTE_ENABLE_N,
  input wire logic [3:0] ADDR,
  input wire logic RD_N,
  input wire logic [15:0] D_OUT,
  input wire logic D_OE,
  input wire logic INTRQ,
  input wire logic DMARQ,
  // core side
  input wire logic CORE_BUSY,
  input wire logic CORE_DMA_REQ,
  input wire logic CORE_DONE,
  input wire logic CORE_XFER_REQ,
  input wire logic CMD_VALID,
  input wire logic [8:0] SECTOR_TOTAL,
  input wire logic LINEAR_BLOCK_MODE,
  input wire logic [27:0] BLOCK_ADDR,
  input wire logic [15:0] CYLINDER,
  input wire logic [3:0] HEAD
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // design busy is internal; rebuilt from the command pulse and completion
  logic busy_seen;
  always_ff @(posedge MCLK) begin
    if (SYS_RST || CORE_DONE) busy_seen <= 1'b0;
    else if (CMD_VALID) busy_seen <= 1'b1;
  end
  // read taken in pc card i/o mode
  sequence s_rd(logic [3:0] a, logic [1:0] be);
    $fell(RD_N) && ADDR == a && !TRUE_IDE && IO_MODE && !REG_N
      && {ODD_BYTE_ENABLE_N, EVEN_BYTE_ENABLE_N} == be;
  endsequence
  a_busy_status: assert property (s_rd(OFS_STATUS, 2'b00) ##0 CORE_BUSY
    |=> D_OE && D_OUT[7:0] == 8'h80) else $error("status not 80h while busy");
  a_status_clear: assert property (s_rd(OFS_STATUS, 2'b00) ##0 !CORE_DONE
    |=> !INTRQ) else $error("status read left interrupt");
  a_alt_keep: assert property (s_rd(OFS_ALT_STATUS, 2'b00) ##0 INTRQ
    |=> INTRQ) else $error("alternate read dropped interrupt");
  a_err_zeros: assert property (D_OE && ADDR == OFS_ERROR
    |-> (D_OUT & 16'h002A) == 16'h0000) else $error("error bits 5 3 1 set");
  a_hi_lane_err: assert property (s_rd(OFS_DATA, 2'b01)
    |=> D_OE && (D_OUT & 16'h2A00) == 16'h0000) else $error("upper lane error bad");
  a_index_zero: assert property (D_OE && ADDR == OFS_STATUS
    |-> !D_OUT[1]) else $error("status bit 1 set");
  a_dma_gate: assert property (DMARQ |-> CORE_DMA_REQ
    && (CORE_BUSY || busy_seen || CMD_VALID || CORE_XFER_REQ))
    else $error("dma request outside busy or transfer");
  a_count_full: assert property (SECTOR_TOTAL != 9'h000 && SECTOR_TOTAL <= FULL_COUNT)
    else $error("sector total out of range");
  a_lba_form: assert property (LINEAR_BLOCK_MODE
    |-> BLOCK_ADDR[27:8] == {HEAD, CYLINDER}) else $error("block address wrong");
  a_oe_strobe: assert property (D_OE |-> !RD_N)
    else $error("bus driven without read strobe");
endmodule
bind ata_task_file_registers ata_task_file_registers_asserts u_asserts (.*);
`default_nettype wire

// ==== tf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tf_host_model (
  // clock
  input wire logic clk,
  // host strobes and selects
  output logic reg_n,
  output logic even_n,
  output logic odd_n,
  output logic [3:0] addr,
  output logic rd_n,
  output logic wr_n,
  // data lanes
  output logic [15:0] d_in,
  input wire logic [15:0] d_out
);
  initial begin
    reg_n = 1'b0; // i/o mode needs it low
    {even_n, odd_n, rd_n, wr_n} = 4'hF;
    addr = 4'h0;
    d_in = 16'h0000;
  end
  // be is {odd, even}; strobe idles one cycle between accesses
  task automatic acc(input logic wr, input logic [1:0] be, input logic [3:0] a,
      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    #1;
    addr = a;
    {odd_n, even_n} = be;
    d_in = d;
    rd_n = wr;
    wr_n = !wr;
    repeat (2) @(posedge clk);
    #1;
    q = d_out;
    {rd_n, wr_n, odd_n, even_n} = 4'hF;
    // released lanes must not keep the old value
    d_in = ~d;
  endtask
endmodule
`default_nettype wire

// ==== tb_ata_task_file_registers.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_ata_task_file_registers import ata_tf_pkg::*;;
  typedef struct packed {
    logic [3:0] ofs;
    logic [7:0] val;
  } row_t;
  row_t rows [5] = '{'{OFS_COUNT, 8'h00}, '{OFS_SECTOR, 8'h11}, '{OFS_CYL_LO, 8'h22},
    '{OFS_CYL_HI, 8'h33}, '{OFS_UNIT_HEAD, 8'hE5}};
  logic MCLK = 1'b0;
  logic SYS_RST, CORE_READY, CORE_BUSY, CORE_UNIT_COPY, CORE_EIGHT_BIT, CORE_XFER_REQ;
  logic CORE_WRITE_DIR, CORE_DMA_REQ, CORE_SECTOR_DONE, CORE_CORRECTED, CORE_DONE;
  logic CORE_WRITE_FAULT, CORE_RVALID, CORE_WREADY, REG_N, EVEN_BYTE_ENABLE_N;
  logic ODD_BYTE_ENABLE_N, RD_N, WR_N, D_OE, INTRQ, DMARQ, CMD_VALID, LINEAR_BLOCK_MODE;
  logic SOFT_RESET, CORE_RREADY, CORE_WVALID;
  logic [3:0] ADDR, HEAD;
  logic [7:0] CORE_ERR_BITS, CMD_CODE, FEATURE;
  logic [8:0] SECTOR_TOTAL;
  logic [15:0] D_IN, D_OUT, CORE_RDATA, CORE_WDATA, CYLINDER, q;
  logic [27:0] CORE_FAIL_ADDR, BLOCK_ADDR;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  // pc card i/o straps; ide selects idle
  logic TRUE_IDE = 1'b0;
  logic IO_MODE = 1'b1;
  logic CS0_N = 1'b1;
  wire logic CS1_N = 1'b1;
  logic DMACK_N = 1'b1;
  int cmd_seen = 0;
  int pops = 0;
  always #4 MCLK = ~MCLK;
  // one-cycle pulses are counted so none slips between two checks
  always @(posedge MCLK) begin
    if (CMD_VALID === 1'b1) cmd_seen++;
    if (CORE_RREADY === 1'b1) pops++;
  end
  ata_task_file_registers uut (.*);
  tf_host_model host (.clk(MCLK), .reg_n(REG_N), .even_n(EVEN_BYTE_ENABLE_N),
    .odd_n(ODD_BYTE_ENABLE_N), .addr(ADDR), .rd_n(RD_N), .wr_n(WR_N), .d_in(D_IN),
    .d_out(D_OUT));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    host.acc(1'b1, 2'b00, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [15:0] e);
    host.acc(1'b0, 2'b00, a, 16'h0000, q);
    chk(nm, e, q);
  endtask
  task automatic pulse(ref logic s);
    @(posedge MCLK);
    #1;
    s = 1'b1;
    @(posedge MCLK);
    #1;
    s = 1'b0;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    SYS_RST = 1'b1;
    {CORE_READY, CORE_BUSY, CORE_UNIT_COPY, CORE_EIGHT_BIT, CORE_XFER_REQ} = '0;
    {CORE_WRITE_DIR, CORE_DMA_REQ, CORE_SECTOR_DONE, CORE_CORRECTED, CORE_DONE} = '0;
    {CORE_WRITE_FAULT, CORE_RVALID, CORE_WREADY, CORE_ERR_BITS} = '0;
    {CORE_FAIL_ADDR, CORE_RDATA} = '0;
    repeat (16) @(posedge MCLK);
    #1;
    SYS_RST = 1'b0;
    chk("d_oe", 0, D_OE);
    chk("intrq", 0, INTRQ);
    rdc("unit_head", OFS_UNIT_HEAD, 16'h00A0);
    rdc("status", OFS_STATUS, 16'h0000);
    CORE_READY = 1'b1;
    rdc("status", OFS_STATUS, 16'h0050);
    foreach (rows[i]) wr(rows[i].ofs, {8'h00, rows[i].val});
    foreach (rows[i]) rdc("reg", rows[i].ofs, {8'h00, rows[i].val});
    chk("total", 16'h0100, SECTOR_TOTAL);
    chk("lba", 28'h5332211, BLOCK_ADDR);
    chk("linear", 1, LINEAR_BLOCK_MODE);
    wr(OFS_UNIT_HEAD, 16'h00A3);
    chk("linear", 0, LINEAR_BLOCK_MODE);
    chk("head", 3, HEAD);
    host.acc(1'b1, 2'b01, OFS_DATA, 16'h3C00, q);
    chk("feature", 8'h3C, FEATURE);
    // failing command, core busy for a while
    wr(OFS_COUNT, 16'h0003);
    wr(OFS_STATUS, 16'h0020);
    chk("cmd_code", 8'h20, CMD_CODE);
    CORE_BUSY = 1'b1;
    CORE_DMA_REQ = 1'b1;
    CORE_FAIL_ADDR = 28'h0ABCDEF;
    rdc("status", OFS_STATUS, 16'h0080);
    chk("dmarq", 1, DMARQ);
    CORE_BUSY = 1'b0;
    pulse(CORE_SECTOR_DONE);
    CORE_ERR_BITS = 8'hFF;
    CORE_WRITE_FAULT = 1'b1;
    pulse(CORE_DONE);
    chk("dmarq", 0, DMARQ);
    CORE_DMA_REQ = 1'b0;
    chk("intrq", 1, INTRQ);
    rdc("error", OFS_ERROR, 16'h00D5);
    host.acc(1'b0, 2'b01, OFS_DATA, 16'h0000, q);
    chk("error_hi", 8'hD5, q[15:8]);
    rdc("alt_status", OFS_ALT_STATUS, 16'h0071);
    chk("intrq", 1, INTRQ);
    rdc("status", OFS_STATUS, 16'h0071);
    chk("intrq", 0, INTRQ);
    rdc("count", OFS_COUNT, 16'h0002);
    rdc("sector", OFS_SECTOR, 16'h00EF);
    // memory mode with attribute select low must not hit
    IO_MODE = 1'b0;
    wr(OFS_SECTOR, 16'h0099);
    IO_MODE = 1'b1;
    rdc("sector", OFS_SECTOR, 16'h00EF);
    // clean command with interrupts held off
    wr(OFS_ALT_STATUS, 16'h0002);
    wr(OFS_COUNT, 16'h0001);
    wr(OFS_STATUS, 16'h0020);
    pulse(CORE_CORRECTED);
    CORE_ERR_BITS = 8'h00;
    CORE_WRITE_FAULT = 1'b0;
    pulse(CORE_DONE);
    chk("intrq", 0, INTRQ);
    rdc("alt_status", OFS_ALT_STATUS, 16'h0054);
    rdc("error", OFS_ERROR, 16'h0000);
    rdc("count", OFS_COUNT, 16'h0000);
    wr(OFS_ALT_STATUS, 16'h0000);
    chk("intrq", 1, INTRQ);
    // soft reset held: a command write is ignored
    wr(OFS_ALT_STATUS, 16'h0004);
    chk("soft_reset", 1, SOFT_RESET);
    wr(OFS_STATUS, 16'h0020);
    chk("cmd_seen", 2, cmd_seen);
    wr(OFS_ALT_STATUS, 16'h0000);
    // fill the buffer with the core stalled; word 17 is lost
    CORE_XFER_REQ = 1'b1;
    CORE_WRITE_DIR = 1'b1;
    rdc("alt_status", OFS_ALT_STATUS, 16'h005C);
    for (int i = 0; i < 17; i++) wr(OFS_DATA, 16'hA000 + 16'(i));
    host.acc(1'b0, 2'b00, OFS_ALT_STATUS, 16'h0000, q);
    chk("xfer", 0, q[3]);
    CORE_WREADY = 1'b1;
    n = 0;
    repeat (40) begin
      if (CORE_WVALID === 1'b1) begin
        chk("wdata", 16'hA000 + 16'(n), CORE_WDATA);
        n++;
      end
      @(posedge MCLK);
      #1;
    end
    chk("words", 16, n);
    CORE_WRITE_DIR = 1'b0;
    CORE_RDATA = 16'h5AC3;
    CORE_RVALID = 1'b1;
    rdc("data", OFS_DATA, 16'h5AC3);
    // true ide: eight-bit pio pairs on the low lane, dma ignores the address
    TRUE_IDE = 1'b1;
    CS0_N = 1'b0;
    CORE_EIGHT_BIT = 1'b1;
    rdc("ide_even", OFS_DATA, 16'h00C3);
    rdc("ide_odd", OFS_DATA, 16'h005A);
    CS0_N = 1'b1;
    DMACK_N = 1'b0;
    rdc("dma", 4'h5, 16'h5AC3);
    chk("pops", 3, pops);
    test_done;
  end
endmodule
`default_nettype wire
